// file: verilog/latch_host_pkg.sv
// package of constants and types for the addressable latch host controller
package latch_host_pkg;
    // ********************************************************
    // port word layout and timing
    // ********************************************************
    localparam int ADDR_W        = 3;
    localparam int WORD_W        = 6;
    localparam int BIT_DATA      = 3;
    localparam int BIT_SEL       = 4;
    localparam int BIT_CLR       = 5;
    localparam int CLK_HZ        = 10_000_000;
    localparam int PWM_MIN_HZ    = 400;
    localparam int PWM_STEPS     = 256;
    // pwm period cycles, rounded down to keep frequency >= 400 Hz
    localparam int PWM_CYC       = CLK_HZ / PWM_MIN_HZ;
    localparam int PWM_PRESCALE  = PWM_CYC / PWM_STEPS;
    localparam int PHASE_CYC     = 4;
    localparam int CLEAR_CYC     = 4;
    localparam logic [WORD_W-1:0] WORD_RST = 6'h30;

    typedef struct packed {
        logic             wipe_n;
        logic             sel_n;
        logic             data;
        logic [ADDR_W-1:0] addr;
    } port_word_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic             data;
    } write_req_t;
endpackage : latch_host_pkg

// file: verilog/dim_pwm.sv
// pwm generator for the shared output enable
module dim_pwm
    import latch_host_pkg::*;
#(
    parameter int PRESCALE = PWM_PRESCALE
)(
    input  wire logic       i_ref_clk,   // system clock
    input  wire logic       i_rst,       // async reset, high
    input  wire logic [7:0] i_duty,      // duty, 0 off, ff on
    output logic            o_pwm        // enable level
);
    localparam int PS_W = $clog2(PRESCALE + 1);
    logic [PS_W-1:0] ps_r;
    logic [7:0]      phase_r;

    // prescaler and phase counter, 256 steps per period
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            ps_r    <= '0;
            phase_r <= 8'h00;
        end
        else if (ps_r == PS_W'(PRESCALE - 1))
        begin
            ps_r    <= '0;
            phase_r <= phase_r + 8'h01;
        end
        else
            ps_r <= ps_r + PS_W'(1);
    end

    // duty ff means fully on, 0 fully off
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
            o_pwm <= 1'b0;
        else
            o_pwm <= (i_duty == 8'hff) || (phase_r < i_duty);
    end
endmodule // dim_pwm

// file: verilog/latch_host.sv
// host controller driving the addressable eight output latch device
module latch_host
    import latch_host_pkg::*;
#(
    parameter int PHASE   = PHASE_CYC,
    parameter int CLR_LEN = CLEAR_CYC,
    parameter int PRESC   = PWM_PRESCALE
)(
    input  wire logic              i_ref_clk,  // 10 MHz clock
    input  wire logic              i_rst,      // async reset, high
    input  wire logic              i_wr_valid, // write request
    input  wire logic [ADDR_W-1:0] i_wr_addr,  // channel address
    input  wire logic              i_wr_data,  // 1 on, 0 off
    input  wire logic              i_clr_req,  // clear all request
    input  wire logic [7:0]        i_duty,     // dimming duty
    output logic                   o_wr_ready, // idle, may accept
    output logic [ADDR_W-1:0]      o_addr,     // latch address pins
    output logic                   o_data,     // data pin
    output logic                   o_sel_n,    // unit select, low
    output logic                   o_latch_wipe_n, // clear, low
    output logic                   o_oe,       // output enable
    output logic [7:0]             o_shadow    // host copy of latches
);
    // ********************************************************
    // sequencer
    // ********************************************************
    typedef enum {ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD, ST_CLEAR} st_t;
    st_t              st_r;
    logic [7:0]       cnt_r;
    write_req_t       req_r;
    port_word_t       word_r;
    logic             pwm;
    logic [7:0]       sel_lo_r;   // cycles select has stood low
    logic [7:0]       wipe_lo_r;  // cycles clear has stood low
    logic [7:0]       gap_r;      // cycles since select was last low
    localparam logic [7:0] PH_LAST  = 8'(PHASE - 1);
    localparam logic [7:0] CLR_LAST = 8'(CLR_LEN - 1);
    localparam logic [7:0] SEL_LEN  = 8'(PHASE);
    localparam logic [7:0] WIPE_LEN = 8'(CLR_LEN);
    localparam logic [7:0] GAP_MIN  = 8'(2 * PHASE);

    // state and phase counter; clear has priority over writes
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            st_r  <= ST_CLEAR;  // power-up clears the device
            cnt_r <= 8'h00;
            req_r <= '0;
        end
        else
        begin
            unique case (st_r)
                ST_IDLE:
                begin
                    cnt_r <= 8'h00;
                    if (i_clr_req)
                        st_r <= ST_CLEAR;
                    else if (i_wr_valid)
                    begin
                        req_r <= '{addr: i_wr_addr, data: i_wr_data};
                        st_r  <= ST_SETUP;
                    end
                end
                ST_SETUP, ST_STROBE, ST_HOLD, ST_CLEAR:
                begin
                    if (cnt_r == ((st_r == ST_CLEAR) ? CLR_LAST : PH_LAST))
                    begin
                        cnt_r <= 8'h00;
                        unique case (st_r)
                            ST_SETUP:  st_r <= ST_STROBE;
                            ST_STROBE: st_r <= ST_HOLD;
                            default:   st_r <= ST_IDLE;
                        endcase
                    end
                    else
                        cnt_r <= cnt_r + 8'h01;
                end
            endcase
        end
    end

    // ********************************************************
    // port word, one flop per pin
    // ********************************************************
    // address and data steady in all three write phases
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
            word_r <= port_word_t'(WORD_RST);
        else
        begin
            word_r.addr   <= req_r.addr;
            word_r.data   <= req_r.data;
            word_r.sel_n  <= !(st_r == ST_STROBE);
            word_r.wipe_n <= !(st_r == ST_CLEAR);
        end
    end

    // shadow of device latch contents
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
            o_shadow <= 8'h00;
        else if (st_r == ST_CLEAR)
            o_shadow <= 8'h00;
        else if (st_r == ST_STROBE && cnt_r == 8'h00)
            o_shadow[req_r.addr] <= req_r.data;
    end

    // ready flag registered
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
            o_wr_ready <= 1'b0;
        else
            o_wr_ready <= (st_r == ST_IDLE) && !i_wr_valid && !i_clr_req;
    end

    // enable: pwm shared by all channels, active high
    dim_pwm #(.PRESCALE(PRESC)) u_pwm (
        .i_ref_clk (i_ref_clk),
        .i_rst     (i_rst),
        .i_duty    (i_duty),
        .o_pwm     (pwm)
    );
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
            o_oe <= 1'b0;
        else
            o_oe <= pwm;
    end

    assign o_addr         = word_r.addr;
    assign o_data         = word_r.data;
    assign o_sel_n        = word_r.sel_n;
    assign o_latch_wipe_n = word_r.wipe_n;

    // ********************************************************
    // checks
    // ********************************************************
    // length of the current select pulse
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
            sel_lo_r <= 8'h00;
        else if (!o_sel_n)
            sel_lo_r <= sel_lo_r + 8'h01;
        else
            sel_lo_r <= 8'h00;
    end

    // length of the current clear pulse
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
            wipe_lo_r <= 8'h00;
        else if (!o_latch_wipe_n)
            wipe_lo_r <= wipe_lo_r + 8'h01;
        else
            wipe_lo_r <= 8'h00;
    end

    // gap since the last strobe, saturating so the first write passes
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
            gap_r <= 8'hff;
        else if (!o_sel_n)
            gap_r <= 8'h00;
        else if (gap_r != 8'hff)
            gap_r <= gap_r + 8'h01;
    end

    // select strobe shape and spacing
    AST_SEL_LOW_LEN: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        $rose(o_sel_n) |-> sel_lo_r == SEL_LEN)
        else $error("select low width wrong");
    AST_ADDR_STEADY: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        !o_sel_n |-> $stable(o_addr) && $stable(o_data))
        else $error("address or data moved during strobe");
    AST_SETUP_BEFORE: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        $fell(o_sel_n) |-> $past(o_sel_n, 2) && $stable(o_addr))
        else $error("no setup before strobe");
    AST_SEL_GAP: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        $fell(o_sel_n) |-> gap_r >= GAP_MIN)
        else $error("strobes too close together");
    AST_DATA_HELD_HIGH: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        $rose(o_sel_n) |-> $stable(o_addr) && $stable(o_data))
        else $error("address or data moved at select release");
    AST_TAKE_PINS: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        o_wr_ready && i_wr_valid && !i_clr_req |->
            ##2 (o_addr == $past(i_wr_addr, 2) && o_data == $past(i_wr_data, 2)))
        else $error("pins do not carry the taken request");
    AST_TAKE_TO_STROBE: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        o_wr_ready && i_wr_valid && !i_clr_req |-> ##6 $fell(o_sel_n))
        else $error("strobe not at expected cycle");
    // clear pulse
    AST_CLR_NO_SEL: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        !o_latch_wipe_n |-> o_sel_n)
        else $error("strobe during clear");
    AST_CLR_SHADOW: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        !o_latch_wipe_n |-> o_shadow == 8'h00)
        else $error("shadow not cleared");
    AST_WIPE_LEN: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        $rose(o_latch_wipe_n) |-> wipe_lo_r == WIPE_LEN)
        else $error("clear low width wrong");
    AST_CLR_TAKE: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        o_wr_ready && i_clr_req |-> ##2 !o_latch_wipe_n)
        else $error("clear request not sent");
    // shadow image of the latches
    AST_SHADOW_WR: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        $fell(o_sel_n) |-> o_shadow[o_addr] == o_data)
        else $error("shadow mismatch after strobe");
    AST_ONE_CHANNEL: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        $fell(o_sel_n) |-> o_shadow ==
            (($past(o_shadow) & ~(8'h01 << o_addr)) | (8'(o_data) << o_addr)))
        else $error("strobe touched another channel");
    AST_SHADOW_QUIET: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        $changed(o_shadow) |-> $fell(o_sel_n) || !o_latch_wipe_n)
        else $error("shadow moved without strobe or clear");
    // idle handshake
    AST_READY_IDLE: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        o_wr_ready |-> o_sel_n && o_latch_wipe_n)
        else $error("ready while busy");
    AST_READY_STEADY: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        o_wr_ready |-> $stable(o_addr) && $stable(o_data))
        else $error("pins moved while idle");
    // shared output enable
    AST_OE_OFF: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        i_duty == 8'h00 |-> ##2 !o_oe)
        else $error("enable on at zero duty");
    AST_OE_ON: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        i_duty == 8'hff |-> ##2 o_oe)
        else $error("enable off at full duty");
endmodule // latch_host

// file: verification/latch_dev_model.sv
// behavioural model of the addressable eight output latch device
module latch_dev_model
    import latch_host_pkg::*;
(
    input  wire logic [ADDR_W-1:0] i_addr,   // latch address
    input  wire logic              i_data,   // data level
    input  wire logic              i_sel_n,  // unit select, low
    input  wire logic              i_wipe_n, // clear, low
    input  wire logic              i_oe,     // output enable, high
    output logic      [7:0]        o_lat,    // latch contents
    output logic      [7:0]        o_sw      // switch states
);
    timeunit 1ns;
    timeprecision 1ns;
    // static latches start at zero
    initial o_lat = 8'h00;
    // capture on select fall only, clear wins over strobe
    always @(negedge i_sel_n or negedge i_wipe_n)
    begin
        if (!i_wipe_n)
            o_lat <= 8'h00;
        else
            o_lat[i_addr] <= i_data;
    end
    // one enable gates every channel
    assign o_sw = o_lat & {8{i_oe}};
endmodule // latch_dev_model

// file: verification/latch_host_test.sv
// self-checking bench for the latch host controller
module latch_host_test
    import latch_host_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic [ADDR_W-1:0] a;
        logic              d;
        logic [7:0]        exp;
    } row_t;
    logic              ref_clk, rst, wr_valid, wr_data, clr_req;
    logic [ADDR_W-1:0] wr_addr, addr;
    logic [7:0]        duty, shadow, lat, sw;
    logic              wr_ready, dat, sel_n, wipe_n, oe;
    logic [5:0]        pw, pw_exp;
    int                failures, tests_run, cycles, hi;
    // writes and latch image expected after each
    row_t rows [6] = '{'{3'h0, 1'b1, 8'h01}, '{3'h7, 1'b1, 8'h81},
        '{3'h3, 1'b1, 8'h89}, '{3'h0, 1'b0, 8'h88},
        '{3'h7, 1'b0, 8'h08}, '{3'h5, 1'b1, 8'h28}};
    latch_host #(.PRESC(1)) dut (.i_ref_clk(ref_clk), .i_rst(rst),
        .i_wr_valid(wr_valid), .i_wr_addr(wr_addr), .i_wr_data(wr_data),
        .i_clr_req(clr_req), .i_duty(duty), .o_wr_ready(wr_ready),
        .o_addr(addr), .o_data(dat), .o_sel_n(sel_n),
        .o_latch_wipe_n(wipe_n), .o_oe(oe), .o_shadow(shadow));
    latch_dev_model dev (.i_addr(addr), .i_data(dat), .i_sel_n(sel_n),
        .i_wipe_n(wipe_n), .i_oe(oe), .o_lat(lat), .o_sw(sw));
    // port word as the host drives it, weights 1 to 32
    assign pw = {wipe_n, sel_n, dat, addr};
    // ****************************************************
    // helper tasks
    // ****************************************************
    task automatic chk(input string nm, input logic [15:0] seen, exp);
        tests_run++;
        if (seen !== exp)
        begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #5;
    endtask
    task automatic wait_ready;
        repeat (100) if (wr_ready !== 1'b1) tick(1);
        chk("wr_ready", 16'(wr_ready), 16'h1);
    endtask
    // hold the request until taken, then wait for idle
    task automatic req(input logic v, c, input logic [ADDR_W-1:0] a,
                       input logic d);
        wait_ready();
        wr_valid = v;
        clr_req = c;
        wr_addr = a;
        wr_data = d;
        repeat (20) if (wr_ready === 1'b1) tick(1);
        wr_valid = 1'b0;
        clr_req = 1'b0;
        wait_ready();
    endtask
    task automatic oe_count;
        hi = 0;
        repeat (512)
        begin
            tick(1);
            hi += (oe === 1'b1) ? 1 : 0;
        end
    endtask
    // cycles from one rise of the enable to the next
    task automatic oe_period;
        repeat (300) if (oe !== 1'b0) tick(1);
        repeat (300) if (oe !== 1'b1) tick(1);
        hi = 0;
        repeat (300)
            if (oe !== 1'b0)
            begin
                tick(1);
                hi++;
            end
        repeat (300)
            if (oe !== 1'b1)
            begin
                tick(1);
                hi++;
            end
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // ****************************************************
    // clock, timeout and main sequence
    // ****************************************************
    initial
    begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            failures++;
            report_and_stop();
        end
    end
    initial
    begin
        {wr_valid, wr_data, clr_req, wr_addr} = '0;
        duty = 8'hff;
        rst = 1'b1;
        tick(2);
        chk("sel_in_reset", 16'(sel_n), 16'h1);
        rst = 1'b0;
        tick(1);
        chk("wipe_powerup", 16'(wipe_n), 16'h0);
        wait_ready();
        chk("lat_powerup", 16'(lat), 16'h0);
        foreach (rows[i])
        begin
            req(1'b1, 1'b0, rows[i].a, rows[i].d);
            chk("addr_pins", 16'(addr), 16'(rows[i].a));
            pw_exp = 6'h30 | 6'(rows[i].a) | (6'(rows[i].d) * 6'h8);
            chk("port_word", 16'(pw), 16'(pw_exp));
            chk("latches", 16'(lat), 16'(rows[i].exp));
            chk("shadow", 16'(shadow), 16'(rows[i].exp));
            chk("switches", 16'(sw), 16'(rows[i].exp));
        end
        duty = 8'h00;
        tick(300);
        oe_count();
        chk("oe_off", 16'(hi), 16'h0);
        chk("lat_kept", 16'(lat), 16'h28);
        duty = 8'hff;
        tick(300);
        oe_count();
        chk("oe_on", 16'(hi), 16'd512);
        duty = 8'h40;
        tick(3);
        oe_count();
        chk("oe_quarter", 16'(hi), 16'h80);
        oe_period();
        chk("pwm_period", 16'(hi), 16'(PWM_STEPS));
        req(1'b0, 1'b1, 3'h0, 1'b0);
        chk("lat_cleared", 16'(lat), 16'h0);
        chk("shadow_cleared", 16'(shadow), 16'h0);
        req(1'b1, 1'b0, 3'h2, 1'b1);
        chk("lat_ch2", 16'(lat), 16'h04);
        rst = 1'b1;
        tick(1);
        chk("oe_in_reset", 16'(oe), 16'h0);
        rst = 1'b0;
        tick(1);
        chk("wipe_rerun", 16'(wipe_n), 16'h0);
        wait_ready();
        chk("lat_rerun", 16'(lat), 16'h0);
        report_and_stop();
    end
endmodule // latch_host_test
